/* File: ctrl_status_reg_protect_and_trip_prog.sv */
// serial slave for the control/status register, write protection and threshold programming
`timescale 1ns/1ps
`include "csr_defines.svh"

// Notes on behaviour
// - register reached by slave address 1010010 then address byte FFh.
// - only one data byte; a further byte is not acknowledged and aborts the write.
// - stop after a third-step byte with bit 2 clear starts the nonvolatile lock store.
// - writing 02h sets the write enable latch, volatile, no delay.
// - writing 06h sets both latches; needed before a nonvolatile update.
// - third step byte 0xy0t010 updates both monitor flags and the lock.
// - nonvolatile cycle lasts 5 ms, then clears the register write latch.
// - bit 2 set in third step keeps register latch set, lock untouched.
// - lock writes ignored while the write protect pin is high.
// - read uses slave byte 10100101 and address FFh, one byte returned.
// - slave goes idle after the first read byte; master still stops.
// - a register read never disturbs the latches or the write sequence.
// - reserved bits 7, 4 and 0 always read as zero.
// - protect pin blocks register and pot nonvolatile writes; lock blocks pot writes.
// - nonvolatile cycle starts only after a correct clock count before stop.
// - monitor 2 trip output rises above threshold and clears its flag.
// - monitor 3 trip output rises above threshold and clears its flag.
// - raise threshold: program voltage, A0h, 09h or 0Dh, data 00h, stop.
// - reset threshold: program voltage, A0h, 0Bh or 0Fh, data 00h, stop.
// - threshold writes need no write enable latch.
// - writes other than 02h with the write enable latch clear abort without data acknowledge.
// - flags start at zero, set only while trip high, clear when low.
// - volatile bits power up zero; the lock keeps its stored value.
module ctrl_status_reg_protect_and_trip_prog #(
  parameter int NV_WRITE_CYCLES = `CSR_NV_WRITE_MS * 1000 * `CSR_CLK_MHZ
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic WP_HIGH,
  input wire logic WP_PROG,
  input wire logic MON2_ABOVE,
  input wire logic MON3_ABOVE,
  input wire logic LOCK_STORED,
  output logic MON2_TRIP_OUTPUT,
  output logic MON3_TRIP_OUTPUT,
  output logic WIPER_WRITE_LOCK,
  output logic POT_VOL_WRITE_OK,
  output logic POT_NV_WRITE_OK,
  output logic NV_BUSY,
  output logic TRIP_PROG_STROBE,
  output logic TRIP_PROG_ACTIVE,
  output logic TRIP_PROG_MON3,
  output logic TRIP_PROG_RESET
);

  // =====================================================================
  // state
  // one packed struct holds every flip-flop of the block
  csr_pkg::state_t st_q;
  csr_pkg::state_t st_d;

  // decoded bus events, received byte and register image
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] byte_in;
  logic [7:0] reg_view;
  logic prog_fall;

  // true for one of the four threshold byte addresses
  function automatic logic is_trip_addr(input logic [7:0] a);
    is_trip_addr = (a == `CSR_TRIP2_RAISE) || (a == `CSR_TRIP3_RAISE) ||
                   (a == `CSR_TRIP2_RESET) || (a == `CSR_TRIP3_RESET);
  endfunction : is_trip_addr

  // true when a threshold address targets monitor 3
  function automatic logic is_mon3_addr(input logic [7:0] a);
    is_mon3_addr = (a == `CSR_TRIP3_RAISE) || (a == `CSR_TRIP3_RESET);
  endfunction : is_mon3_addr

  // true when a threshold address asks for the nominal reset level
  function automatic logic is_reset_addr(input logic [7:0] a);
    is_reset_addr = (a == `CSR_TRIP2_RESET) || (a == `CSR_TRIP3_RESET);
  endfunction : is_reset_addr

  // true for a register data byte the slave may take
  function automatic logic reg_write_ok(input logic en, input logic prot, input logic [7:0] b);
    // the enable byte itself must pass while the latch is still clear
    reg_write_ok = (en || b == `CSR_WEL_SET) && !prot;
  endfunction : reg_write_ok

  // true while the slave follows the bit clock
  function automatic logic is_listening(input csr_pkg::phase_t p);
    is_listening = (p != csr_pkg::PH_IDLE) && (p != csr_pkg::PH_SKIP);
  endfunction : is_listening

  // =====================================================================
  // edges and conditions seen on the synchronised pins
  // every pin is seen two clocks late; the third stage is history only
  assign scl_rise = st_q.scl.s2 & ~st_q.scl.s3;
  assign scl_fall = ~st_q.scl.s2 & st_q.scl.s3;
  assign bus_start = st_q.scl.s2 & st_q.scl.s3 & ~st_q.sda.s2 & st_q.sda.s3;
  assign bus_stop = st_q.scl.s2 & st_q.scl.s3 & st_q.sda.s2 & ~st_q.sda.s3;
  assign byte_in = {st_q.rx[6:0], st_q.sda.s2};
  assign prog_fall = ~st_q.prog.s2 & st_q.prog.s3;

  // register image with reserved bits forced low
  // (whatever the master wrote to them, they read back as zero)
  always_comb begin
    reg_view = 8'h00;
    reg_view[`CSR_BIT_FLAG2] = st_q.flag2;
    reg_view[`CSR_BIT_FLAG3] = st_q.flag3;
    reg_view[`CSR_BIT_LOCK] = st_q.lock;
    reg_view[`CSR_BIT_REG_WRITE_ENABLE_LATCH] = st_q.reg_write_enable_latch;
    reg_view[`CSR_BIT_WEL] = st_q.write_enable_latch;
  end

  // =====================================================================
  // next state
  always_comb begin
    // hold everything by default; the strobe is a one-cycle pulse
    st_d = st_q;
    st_d.trip_strobe = 1'b0;

    // pin synchronisers
    // only the second stage reads the first
    st_d.scl = '{s1: SCL, s2: st_q.scl.s1, s3: st_q.scl.s2};
    st_d.sda = '{s1: SDA_IN, s2: st_q.sda.s1, s3: st_q.sda.s2};
    st_d.wp = '{s1: WP_HIGH, s2: st_q.wp.s1, s3: st_q.wp.s2};
    st_d.prog = '{s1: WP_PROG, s2: st_q.prog.s1, s3: st_q.prog.s2};
    st_d.above2 = '{s1: MON2_ABOVE, s2: st_q.above2.s1, s3: st_q.above2.s2};
    st_d.above3 = '{s1: MON3_ABOVE, s2: st_q.above3.s1, s3: st_q.above3.s2};

    // stored lock value caught once after reset release
    // (reset clears the lock along with the volatile bits; the lock then comes from storage)
    if (!st_q.init_done) begin
      st_d.init_done = 1'b1;
      st_d.lock = LOCK_STORED;
    end

    // monitor outputs follow the comparators
    // a flag also clears on the rising trip edge, so a write that lands
    // in that cycle sees the old low trip and cannot leave a stale flag
    st_d.trip2 = st_q.above2.s2;
    st_d.trip3 = st_q.above3.s2;
    if ((st_q.above2.s2 & ~st_q.trip2) | ~st_q.trip2) begin
      st_d.flag2 = 1'b0;
    end
    if ((st_q.above3.s2 & ~st_q.trip3) | ~st_q.trip3) begin
      st_d.flag3 = 1'b0;
    end

    // nonvolatile cycle timer
    // the lock only changes at the end, so WIPER_WRITE_LOCK keeps the old
    // value during the cycle; no bus transfer is taken while it runs
    if (st_q.busy) begin
      if (st_q.nv_cnt <= 32'd1) begin
        // last cycle: free the bus and store the new lock
        st_d.busy = 1'b0;
        st_d.reg_write_enable_latch = 1'b0;
        st_d.lock = st_q.lock_new;
      end else begin
        st_d.nv_cnt = st_q.nv_cnt - 32'd1;
      end
    end

    // threshold operation completes when the program voltage is removed
    // the operation stays active for the whole programming window
    if (st_q.trip_op.active && prog_fall) begin
      st_d.trip_op.active = 1'b0;
    end

    // start, stop and bit clocking
    // a start or repeated start drops any pending write
    // a stop ends every frame and commits only a clean one
    if (bus_start) begin
      st_d.phase = csr_pkg::PH_DEV;
      st_d.cnt = 4'd0;
      st_d.oe = 1'b0;
      st_d.pending = 1'b0;
    end else if (bus_stop) begin
      // commit only on a complete, clean frame; the rising clock of the
      // stop itself is counted, so a clean frame ends with the count at one
      if (st_q.pending && st_q.phase == csr_pkg::PH_EXTRA && st_q.cnt == 4'd1) begin
        if (st_q.mode_trip) begin
          // threshold write: one strobe, then active until the voltage drops
          st_d.trip_strobe = 1'b1;
          st_d.trip_op.active = 1'b1;
          st_d.trip_op.mon3 = is_mon3_addr(st_q.trip_addr);
          st_d.trip_op.reset = is_reset_addr(st_q.trip_addr);
        end else if (!st_q.reg_write_enable_latch) begin
          // volatile step: enable latches only
          // 02h sets the enable latch alone, 06h sets both
          st_d.write_enable_latch = st_q.pend_byte[`CSR_BIT_WEL];
          st_d.reg_write_enable_latch = st_q.pend_byte[`CSR_BIT_REG_WRITE_ENABLE_LATCH] & st_q.pend_byte[`CSR_BIT_WEL];
        end else begin
          // third step: flags, then lock store unless bit 2 holds the latch
          // a flag can only be set while its trip output stands high
          st_d.write_enable_latch = st_q.pend_byte[`CSR_BIT_WEL];
          st_d.flag2 = st_q.pend_byte[`CSR_BIT_FLAG2] & st_q.trip2;
          st_d.flag3 = st_q.pend_byte[`CSR_BIT_FLAG3] & st_q.trip3;
          if (st_q.pend_byte[`CSR_BIT_REG_WRITE_ENABLE_LATCH]) begin
            st_d.reg_write_enable_latch = 1'b1;
          end else if (!st_q.wp.s2) begin
            // lock store runs only with the protect pin low
            st_d.lock_new = st_q.pend_byte[`CSR_BIT_LOCK];
            st_d.busy = 1'b1;
            st_d.nv_cnt = 32'(NV_WRITE_CYCLES);
          end
        end
      end
      st_d.phase = csr_pkg::PH_IDLE;
      st_d.pending = 1'b0;
      st_d.oe = 1'b0;
    end else if (is_listening(st_q.phase)) begin
      // sample on the synchronised rising clock, count every clock
      if (scl_rise) begin
        st_d.cnt = st_q.cnt + 4'd1;
        if (st_q.cnt < 4'd8) begin
          st_d.rx = byte_in;
          if (st_q.phase == csr_pkg::PH_READ) begin
            st_d.tx = {st_q.tx[6:0], 1'b0};
          end
        end

        // decide the answer on the eighth bit
        // ack stays low for any byte that no branch takes
        if (st_q.cnt == 4'd7) begin
          st_d.ack = 1'b0;
          st_d.next_phase = csr_pkg::PH_SKIP;
          case (st_q.phase)
            csr_pkg::PH_DEV: begin
              // a busy slave refuses every device byte
              if (!st_q.busy) begin
                if (byte_in == `CSR_DEV_WRITE) begin
                  st_d.ack = 1'b1;
                  st_d.mode_trip = 1'b0;
                  st_d.next_phase = csr_pkg::PH_ADDR;
                end else if (byte_in == `CSR_DEV_READ) begin
                  st_d.ack = 1'b1;
                  st_d.next_phase = csr_pkg::PH_READ;
                end else if (byte_in == `CSR_DEV_TRIP) begin
                  st_d.ack = 1'b1;
                  st_d.mode_trip = 1'b1;
                  st_d.next_phase = csr_pkg::PH_ADDR;
                end
              end
            end
            csr_pkg::PH_ADDR: begin
              // register offset for a slave byte, or one of four threshold cells
              if (!st_q.mode_trip && byte_in == `CSR_REG_OFFSET) begin
                st_d.ack = 1'b1;
                st_d.next_phase = csr_pkg::PH_DATA;
              end else if (st_q.mode_trip && is_trip_addr(byte_in)) begin
                st_d.ack = 1'b1;
                st_d.trip_addr = byte_in;
                st_d.next_phase = csr_pkg::PH_DATA;
              end
            end
            csr_pkg::PH_DATA: begin
              // threshold data needs the program voltage, not the enable latch
              if (st_q.mode_trip) begin
                if (st_q.prog.s2 && byte_in == `CSR_TRIP_DATA) begin
                  st_d.ack = 1'b1;
                  st_d.pending = 1'b1;
                  st_d.next_phase = csr_pkg::PH_EXTRA;
                end
              end else if (reg_write_ok(st_q.write_enable_latch, st_q.wp.s2, byte_in)) begin
                st_d.ack = 1'b1;
                st_d.pending = 1'b1;
                st_d.pend_byte = byte_in;
                st_d.next_phase = csr_pkg::PH_EXTRA;
              end
            end
            csr_pkg::PH_EXTRA: begin
              // a second data byte is refused and drops the write
              st_d.pending = 1'b0;
            end
            default: begin
              // a read returns one byte, then the slave goes idle
              st_d.next_phase = csr_pkg::PH_SKIP;
            end
          endcase
        end
      end else if (scl_fall) begin
        // falling clock: drive or release the data line
        if (st_q.cnt == 4'd8) begin
          // acknowledge slot, master answers in read
          // the answer was decided on the eighth rising clock
          st_d.oe = (st_q.phase == csr_pkg::PH_READ) ? 1'b0 : st_q.ack;
        end else if (st_q.cnt == 4'd9) begin
          // end of the slot: move on, and load the image for a read
          st_d.cnt = 4'd0;
          st_d.phase = st_q.next_phase;
          st_d.oe = 1'b0;
          if (st_q.next_phase == csr_pkg::PH_READ) begin
            st_d.tx = reg_view;
            st_d.oe = ~reg_view[7];
          end
        end else if (st_q.phase == csr_pkg::PH_READ && st_q.cnt != 4'd0) begin
          // next read bit, most significant first
          st_d.oe = ~st_q.tx[7];
        end
      end
    end
  end

  // =====================================================================
  // state register
  // volatile bits clear; the bus lines idle high in the synchronisers
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= '0;
      st_q.write_enable_latch <= `CSR_RST_WEL;
      st_q.reg_write_enable_latch <= `CSR_RST_REG_WRITE_ENABLE_LATCH;
      st_q.flag2 <= `CSR_RST_FLAG;
      st_q.flag3 <= `CSR_RST_FLAG;
      st_q.lock <= `CSR_RST_LOCK;
      st_q.scl <= 3'b111;
      st_q.sda <= 3'b111;
      st_q.phase <= csr_pkg::PH_IDLE;
      st_q.next_phase <= csr_pkg::PH_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // =====================================================================
  // outputs
  // permissions are levels for the pot datapath outside this block
  // open drain data: the line is pulled low or released, never driven high
  assign SDA_OUT = 1'b0; // open drain, low only
  assign SDA_OE = st_q.oe;
  assign MON2_TRIP_OUTPUT = st_q.trip2;
  assign MON3_TRIP_OUTPUT = st_q.trip3;
  assign WIPER_WRITE_LOCK = st_q.lock;
  assign POT_VOL_WRITE_OK = st_q.write_enable_latch & ~st_q.lock;
  assign POT_NV_WRITE_OK = st_q.write_enable_latch & ~st_q.lock & ~st_q.wp.s2;
  assign NV_BUSY = st_q.busy;
  assign TRIP_PROG_STROBE = st_q.trip_strobe;
  assign TRIP_PROG_ACTIVE = st_q.trip_op.active;
  assign TRIP_PROG_MON3 = st_q.trip_op.mon3;
  assign TRIP_PROG_RESET = st_q.trip_op.reset;

endmodule : ctrl_status_reg_protect_and_trip_prog

/* File: csr_defines.svh */
// constants for the control/status register and threshold programming block
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// =====================================================================
// bus addresses
`define CSR_DEV_WRITE 8'ha4
`define CSR_DEV_READ 8'ha5
`define CSR_DEV_TRIP 8'ha0
`define CSR_REG_OFFSET 8'hff
`define CSR_TRIP2_RAISE 8'h09
`define CSR_TRIP3_RAISE 8'h0d
`define CSR_TRIP2_RESET 8'h0b
`define CSR_TRIP3_RESET 8'h0f
`define CSR_TRIP_DATA 8'h00
`define CSR_WEL_SET 8'h02

// =====================================================================
// register field positions
`define CSR_BIT_FLAG2 6
`define CSR_BIT_FLAG3 5
`define CSR_BIT_LOCK 3
`define CSR_BIT_REG_WRITE_ENABLE_LATCH 2
`define CSR_BIT_WEL 1

// =====================================================================
// reset values
`define CSR_RST_WEL 1'b0
`define CSR_RST_REG_WRITE_ENABLE_LATCH 1'b0
`define CSR_RST_FLAG 1'b0
`define CSR_RST_LOCK 1'b0

// =====================================================================
// timing
`define CSR_NV_WRITE_MS 5
`define CSR_CLK_MHZ 250

`endif

/* File: csr_pkg.sv */
// types for the control/status register and threshold programming block
package csr_pkg;

  // =====================================================================
  // bus phase of the serial slave
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_DEV   = 3'b001,
    PH_ADDR  = 3'b010,
    PH_DATA  = 3'b011,
    PH_EXTRA = 3'b100,
    PH_READ  = 3'b101,
    PH_SKIP  = 3'b110
  } phase_t;

  // threshold operation in progress
  typedef struct packed {
    logic active;
    logic mon3;
    logic reset;
  } trip_op_t;

  // two-stage synchroniser plus history stage
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;

  // whole state of the block
  typedef struct packed {
    sync_t scl;
    sync_t sda;
    sync_t wp;
    sync_t prog;
    sync_t above2;
    sync_t above3;
    logic init_done;
    phase_t phase;
    phase_t next_phase;
    logic [3:0] cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic oe;
    logic ack;
    logic mode_trip;
    logic [7:0] trip_addr;
    logic pending;
    logic [7:0] pend_byte;
    logic write_enable_latch;
    logic reg_write_enable_latch;
    logic lock;
    logic lock_new;
    logic flag2;
    logic flag3;
    logic trip2;
    logic trip3;
    logic busy;
    logic [31:0] nv_cnt;
    trip_op_t trip_op;
    logic trip_strobe;
  } state_t;

endpackage : csr_pkg

/* File: csr_checker_properties.sv */
// port checker for the control/status register block
`timescale 1ns/1ps
module csr_checker #(
  parameter int NV_WRITE_CYCLES = 50
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SDA_OE,
  input wire logic WP_HIGH,
  input wire logic WP_PROG,
  input wire logic MON2_ABOVE,
  input wire logic MON3_ABOVE,
  input wire logic MON2_TRIP_OUTPUT,
  input wire logic MON3_TRIP_OUTPUT,
  input wire logic WIPER_WRITE_LOCK,
  input wire logic POT_VOL_WRITE_OK,
  input wire logic POT_NV_WRITE_OK,
  input wire logic NV_BUSY,
  input wire logic TRIP_PROG_STROBE,
  input wire logic TRIP_PROG_ACTIVE
);
  // ====================================================================
  // helper counters
  logic [1:0] age_q;
  logic [31:0] busy_q;
  // age since reset and length of the current busy run
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      age_q <= 2'h0;
      busy_q <= 32'h0;
    end else begin
      age_q <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
      busy_q <= NV_BUSY ? busy_q + 32'h1 : 32'h0;
    end
  end
  // ====================================================================
  // properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence wp_held_s;
    WP_HIGH [*5];
  endsequence
  sequence strobe_s;
    TRIP_PROG_STROBE && TRIP_PROG_ACTIVE ##1 !TRIP_PROG_STROBE;
  endsequence
  trip2_drop_a: assert property ($fell(MON2_ABOVE) |-> ##[1:4] !MON2_TRIP_OUTPUT)
    else $error("monitor 2 trip output did not follow its input");
  trip3_rise_a: assert property ($rose(MON3_ABOVE) |-> ##[1:4] MON3_TRIP_OUTPUT)
    else $error("monitor 3 trip output did not follow its input");
  vol_lock_a: assert property (POT_VOL_WRITE_OK |-> !WIPER_WRITE_LOCK)
    else $error("volatile pot write allowed while locked");
  nv_protect_a: assert property (wp_held_s |-> !POT_NV_WRITE_OK && !$rose(NV_BUSY))
    else $error("nonvolatile write allowed while protected");
  lock_change_a: assert property (age_q == 2'h3 && $changed(WIPER_WRITE_LOCK)
    |-> $past(NV_BUSY) || $past(NV_BUSY, 2))
    else $error("lock bit changed outside a nonvolatile cycle");
  busy_len_a: assert property ($fell(NV_BUSY) |->
    busy_q >= NV_WRITE_CYCLES - 1 && busy_q <= NV_WRITE_CYCLES + 1)
    else $error("nonvolatile cycle length wrong");
  busy_nack_a: assert property (NV_BUSY |-> !SDA_OE)
    else $error("acknowledge given during nonvolatile cycle");
  strobe_once_a: assert property (TRIP_PROG_STROBE |-> strobe_s)
    else $error("threshold strobe not a single pulse with active");
  strobe_prog_a: assert property (TRIP_PROG_STROBE |-> $past(WP_PROG, 4))
    else $error("threshold strobe without program voltage");
  active_drop_a: assert property ($fell(WP_PROG) |-> ##[1:5] !TRIP_PROG_ACTIVE)
    else $error("threshold operation not ended by program voltage drop");
endmodule : csr_checker

/* File: i2c_master_model.sv */
// two-wire bus master model driving the serial clock and data lines
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic low_q;
  // pull-up: the line is high unless a party pulls it low
  assign sda = !(low_q || sda_oe);
  // bus idle, clock stands high
  initial begin
    scl = 1'b1;
    low_q = 1'b0;
  end
  // ====================================================================
  // bit level, every task but stop ends 20 ns after a clock fall; stop ends 20 ns after the data rise
  task automatic start();
    @(posedge clk);
    #1 low_q = 1'b0;
    #20 scl = 1'b1;
    #20 low_q = 1'b1;
    #20 scl = 1'b0;
    #20;
  endtask : start
  task automatic stop();
    low_q = 1'b1;
    #20 scl = 1'b1;
    #20 low_q = 1'b0;
    #20;
  endtask : stop
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      low_q = !b[i];
      #20 scl = 1'b1;
      #40 scl = 1'b0;
      #20;
    end
    low_q = 1'b0;
    #20 scl = 1'b1;
    #20 ack = !sda;
    #20 scl = 1'b0;
    #20;
  endtask : put
  task automatic get(output logic [7:0] b);
    low_q = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #20 scl = 1'b1;
      #20 b[i] = sda;
      #20 scl = 1'b0;
      #20;
    end
    #20 scl = 1'b1;
    #40 scl = 1'b0;
    #20;
  endtask : get
  // ====================================================================
  // frames
  task automatic xfer(input logic [7:0] dv, ad, d0, d1, input int n, output logic [3:0] ak);
    ak = 4'h0;
    start();
    put(dv, ak[3]);
    put(ad, ak[2]);
    if (n > 2) put(d0, ak[1]);
    if (n > 3) put(d1, ak[0]);
    stop();
  endtask : xfer
  task automatic rd(output logic [7:0] v, output logic ok);
    logic a;
    logic b;
    start();
    put(8'ha4, a);
    put(8'hff, b);
    start();
    put(8'ha5, ok);
    get(v);
    stop();
    ok = ok & a & b;
  endtask : rd
endmodule : i2c_master_model

/* File: testbench.sv */
// self-checking bench for the control/status register block
`timescale 1ns/1ps
module testbench;
  localparam int NV = 400;
  typedef struct packed {
    logic [7:0] wr;
    logic [7:0] rd;
  } row_t;
  logic clk, rst, scl, sda, oe, wp, prog, a2, a3, lst, lock, vol, nvo, busy;
  logic stb, act, m3, rs, t2, t3, ok, st_m3, st_rs;
  logic [3:0] ak;
  logic [7:0] rv;
  int mismatches, n_tests, cyc, st_n;
  row_t rows [5] = '{'{8'h02, 8'h02}, '{8'h06, 8'h06}, '{8'h6e, 8'h66}, '{8'h6a, 8'h6a},
    '{8'h00, 8'h68}};
  logic [7:0] tadr [4] = '{8'h0b, 8'h09, 8'h0f, 8'h0d};
  ctrl_status_reg_protect_and_trip_prog #(.NV_WRITE_CYCLES(NV)) dut (
    .CLK(clk), .SYS_RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(oe),
    .WP_HIGH(wp), .WP_PROG(prog), .MON2_ABOVE(a2), .MON3_ABOVE(a3), .LOCK_STORED(lst),
    .MON2_TRIP_OUTPUT(t2), .MON3_TRIP_OUTPUT(t3), .WIPER_WRITE_LOCK(lock),
    .POT_VOL_WRITE_OK(vol), .POT_NV_WRITE_OK(nvo), .NV_BUSY(busy), .TRIP_PROG_STROBE(stb),
    .TRIP_PROG_ACTIVE(act), .TRIP_PROG_MON3(m3), .TRIP_PROG_RESET(rs));
  i2c_master_model mst (.clk(clk), .sda_oe(oe), .scl(scl), .sda(sda));
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // cycle ceiling and threshold strobe capture
  always @(posedge clk) begin
    cyc++;
    if (stb === 1'b1) begin
      st_n++;
      st_m3 = m3;
      st_rs = rs;
    end
    if (cyc == 80000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ====================================================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic idle();
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clk);
    tick(1);
  endtask : idle
  task automatic wr(input logic [7:0] d, input logic [3:0] exp);
    mst.xfer(8'ha4, 8'hff, d, 8'h00, 3, ak);
    chk("write ack", ak, exp);
  endtask : wr
  task automatic rdx(input logic [7:0] exp);
    mst.rd(rv, ok);
    chk("read ack", ok, 8'h01);
    chk("read", rv, exp);
  endtask : rdx
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // ====================================================================
  // main sequence
  initial begin
    rst = 1'b1;
    wp = 1'b0;
    prog = 1'b0;
    a2 = 1'b0;
    a3 = 1'b0;
    lst = 1'b0;
    tick(4);
    rst = 1'b0;
    a2 = 1'b1;
    a3 = 1'b1;
    tick(8);
    chk("trip3", t3, 8'h01);
    foreach (rows[i]) begin
      wr(rows[i].wr, 4'he);
      idle();
      rdx(rows[i].rd);
      chk("reserved", rv & 8'h91, 8'h00);
    end
    $display("register rows done");
    mst.xfer(8'ha4, 8'hff, 8'h02, 8'h02, 4, ak);
    chk("extra ack", ak, 4'he);
    rdx(8'h68);
    $display("extra byte done");
    foreach (tadr[i]) begin
      prog = 1'b1;
      tick(8);
      st_n = 0;
      mst.xfer(8'ha0, tadr[i], 8'h00, 8'h00, 3, ak);
      tick(8);
      chk("trip ack", ak, 4'he);
      chk("strobes", st_n[7:0], 8'h01);
      chk("mon3", st_m3, tadr[i][2]);
      chk("reset op", st_rs, tadr[i][1]);
      chk("active", act, 8'h01);
      prog = 1'b0;
      tick(8);
      chk("active", act, 8'h00);
    end
    mst.xfer(8'ha0, 8'h09, 8'h00, 8'h00, 3, ak);
    chk("trip ack", ak, 4'hc);
    $display("threshold done");
    wr(8'h02, 4'he);
    wr(8'h06, 4'he);
    rdx(8'h6e);
    wp = 1'b1;
    tick(8);
    wr(8'h02, 4'hc);
    chk("nv ok", nvo, 8'h00);
    chk("vol ok", vol, 8'h00);
    chk("lock", lock, 8'h01);
    wp = 1'b0;
    tick(8);
    $display("protect done");
    wr(8'h62, 4'he);
    mst.rd(rv, ok);
    chk("busy ack", ok, 8'h00);
    idle();
    rdx(8'h62);
    chk("lock", lock, 8'h00);
    chk("vol ok", vol, 8'h01);
    chk("nv ok", nvo, 8'h01);
    a2 = 1'b0;
    tick(8);
    chk("trip2", t2, 8'h00);
    rdx(8'h22);
    $display("nonvolatile and monitor done");
    lst = 1'b1;
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    tick(8);
    chk("lock", lock, 8'h01);
    rdx(8'h08);
    $display("reset done");
    report_and_stop();
  end
endmodule : testbench
bind ctrl_status_reg_protect_and_trip_prog csr_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk_i (
  .CLK(CLK), .SYS_RST(SYS_RST), .SDA_OE(SDA_OE), .WP_HIGH(WP_HIGH), .WP_PROG(WP_PROG),
  .MON2_ABOVE(MON2_ABOVE), .MON3_ABOVE(MON3_ABOVE), .MON2_TRIP_OUTPUT(MON2_TRIP_OUTPUT),
  .MON3_TRIP_OUTPUT(MON3_TRIP_OUTPUT), .WIPER_WRITE_LOCK(WIPER_WRITE_LOCK),
  .POT_VOL_WRITE_OK(POT_VOL_WRITE_OK), .POT_NV_WRITE_OK(POT_NV_WRITE_OK), .NV_BUSY(NV_BUSY),
  .TRIP_PROG_STROBE(TRIP_PROG_STROBE), .TRIP_PROG_ACTIVE(TRIP_PROG_ACTIVE));
